// [psu_ctrl_pkg.sv]
// Package of constants and carriers for the supply control and standby role logic
package psu_ctrl_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

  localparam int unsigned OFF_DELAY_MS = 5;
  localparam int unsigned ON_MIN_MS = 5;
  localparam int unsigned ON_MAX_MS = 400;
  localparam int unsigned PWOK_OFF_MS = 5;
  localparam int unsigned PWOK_MIN_MS = 100;
  localparam int unsigned PWOK_MAX_MS = 500;
  localparam int unsigned PARK_SB1_MS = 800;
  localparam int unsigned PARK_SB2_MS = 600;
  localparam int unsigned PARK_SB3_MS = 400;

  localparam int unsigned ON_MIN_CYC = ON_MIN_MS * CYC_PER_MS;
  localparam int unsigned ON_MAX_CYC = ON_MAX_MS * CYC_PER_MS;
  localparam int unsigned PWOK_MIN_CYC = PWOK_MIN_MS * CYC_PER_MS;
  localparam int unsigned PWOK_MAX_CYC = PWOK_MAX_MS * CYC_PER_MS;
  localparam int unsigned PARK_SB1_CYC = PARK_SB1_MS * CYC_PER_MS;
  localparam int unsigned PARK_SB2_CYC = PARK_SB2_MS * CYC_PER_MS;
  localparam int unsigned PARK_SB3_CYC = PARK_SB3_MS * CYC_PER_MS;

  localparam int unsigned CNT_W = 24;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] ROLE_CFG_OFFSET = 8'hD0;
  localparam logic [7:0] ROLE_CFG_RESET = 8'h00;

  localparam logic [7:0] ROLE_STANDARD = 8'h00;
  localparam logic [7:0] ROLE_ACTIVE = 8'h01;
  localparam logic [7:0] ROLE_SB1 = 8'h02;
  localparam logic [7:0] ROLE_SB2 = 8'h03;
  localparam logic [7:0] ROLE_SB3 = 8'h04;
  localparam logic [7:0] ROLE_SB4 = 8'h05;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic temp_warn;
    logic gen_fail;
    logic over_current;
    logic over_voltage;
    logic under_voltage;
    logic fan_fail;
    logic input_loss;
    logic oc_warn;
  } fault_s;

  typedef struct packed {
    logic main_en;
    logic parked;
    logic pgood;
  } pstat_s;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_RAMP = 3'b001,
    ST_PGDLY = 3'b010,
    ST_ON = 3'b011,
    ST_PARK_DLY = 3'b100,
    ST_PARKED = 3'b101
  } pwr_state_e;

endpackage : psu_ctrl_pkg

// [delay_counter.sv]
// Reloadable down counter used for the supply timing windows
`timescale 1ns/1ps
module delay_counter import psu_ctrl_pkg::*; #(
  parameter int unsigned W = CNT_W
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic done_o
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load_i) begin
      cnt_nxt = value_i;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    done_nxt = !load_i && (cnt_r <= {{(W-1){1'b0}}, 1'b1});
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_o = done_r;

endmodule // delay_counter

// [psu_ctrl.sv]
// Power-on sequencing, alert, power-good and standby role control of a supply
`timescale 1ns/1ps
module psu_ctrl import psu_ctrl_pkg::*; #(
  parameter int unsigned ON_DELAY_CYC = ON_MIN_CYC,
  parameter int unsigned PWOK_DELAY_CYC = PWOK_MIN_CYC,
  parameter int unsigned PARK1_CYC = PARK_SB1_CYC,
  parameter int unsigned PARK2_CYC = PARK_SB2_CYC,
  parameter int unsigned PARK3_CYC = PARK_SB3_CYC,
  parameter logic [7:0] SHARE_TH1 = 8'h40,
  parameter logic [7:0] SHARE_TH2 = 8'h60,
  parameter logic [7:0] SHARE_TH3 = 8'h80
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic remote_power_request_n_i,
  input wire fault_s fault_i,
  input wire logic outputs_in_reg_i,
  input wire logic current_limit_i,
  input wire logic wake_line_i,
  input wire logic shared_fault_line_n_i,
  input wire logic [7:0] load_share_level_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_wdata_i,
  output logic [7:0] cmd_rdata_o,
  output logic cmd_rvalid_o,
  output logic alert_n_o,
  output logic alert_n_oe_n_o,
  output logic pgood_o,
  output logic main_en_o,
  output logic parked_o,
  output logic shared_fault_ok_n_o,
  output logic shared_fault_ok_n_oe_n_o
);

  // ==========================================================================
  // Fault aggregation
  // ==========================================================================
  logic any_event;
  logic any_fault;
  logic role_zero_wr;
  logic req_active;
  logic req_drop;
  logic req_prev_r;
  logic req_prev_nxt;

  assign req_active = !remote_power_request_n_i;
  assign any_event = |fault_i;
  assign any_fault = fault_i.gen_fail | fault_i.over_current | fault_i.over_voltage
    | fault_i.under_voltage | fault_i.fan_fail | fault_i.input_loss | fault_i.oc_warn
    | fault_i.temp_warn;
  assign role_zero_wr = cmd_wr_i && (cmd_code_i == ROLE_CFG_OFFSET)
    && (cmd_wdata_i == ROLE_STANDARD);
  assign req_drop = req_prev_r && !req_active;

  // ==========================================================================
  // Role register
  // ==========================================================================
  logic [7:0] role_r;
  logic [7:0] role_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;

  always_comb begin
    role_nxt = role_r;
    if (cmd_wr_i && (cmd_code_i == ROLE_CFG_OFFSET)) begin
      role_nxt = cmd_wdata_i;
    end
    if (any_fault) begin
      role_nxt = ROLE_STANDARD;
    end
    rvalid_nxt = cmd_rd_i;
    rdata_nxt = 8'h00;
    if (cmd_rd_i && (cmd_code_i == ROLE_CFG_OFFSET)) begin
      rdata_nxt = role_r;
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  pwr_state_e state_r;
  pwr_state_e state_nxt;
  logic role_parkable;
  logic wake_now;
  logic [7:0] share_th;
  logic [CNT_W-1:0] park_dly;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_val;
  logic tmr_done;

  always_comb begin
    role_parkable = (role_r == ROLE_SB1) || (role_r == ROLE_SB2)
      || (role_r == ROLE_SB3) || (role_r == ROLE_SB4);
    unique case (role_r)
      ROLE_SB1: begin
        share_th = SHARE_TH1;
        park_dly = CNT_W'(PARK1_CYC);
      end
      ROLE_SB2: begin
        share_th = SHARE_TH2;
        park_dly = CNT_W'(PARK2_CYC);
      end
      default: begin
        share_th = SHARE_TH3;
        park_dly = CNT_W'(PARK3_CYC);
      end
    endcase
    // Wake on fault line, wake line low, own fault or load at or above position threshold
    wake_now = !shared_fault_line_n_i || !wake_line_i || any_fault
      || (load_share_level_i >= share_th);
  end

  always_comb begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_val = '0;
    if (!req_active) begin
      state_nxt = ST_OFF;
    end else begin
      unique case (state_r)
        ST_OFF: begin
          state_nxt = ST_RAMP;
          tmr_load = 1'b1;
          tmr_val = CNT_W'(ON_DELAY_CYC);
        end
        ST_RAMP: begin
          if (tmr_done && outputs_in_reg_i && !current_limit_i) begin
            state_nxt = ST_PGDLY;
            tmr_load = 1'b1;
            tmr_val = CNT_W'(PWOK_DELAY_CYC);
          end
        end
        ST_PGDLY: begin
          if (!outputs_in_reg_i || current_limit_i) begin
            state_nxt = ST_RAMP;
          end else if (tmr_done) begin
            state_nxt = ST_ON;
          end
        end
        ST_ON: begin
          if (!outputs_in_reg_i || fault_i.input_loss) begin
            state_nxt = ST_RAMP;
          end else if (role_parkable && shared_fault_line_n_i && wake_line_i
              && !any_fault && (load_share_level_i < share_th)) begin
            state_nxt = ST_PARK_DLY;
            tmr_load = 1'b1;
            tmr_val = park_dly;
          end
        end
        ST_PARK_DLY: begin
          if (!outputs_in_reg_i || fault_i.input_loss) begin
            state_nxt = ST_RAMP;
          end else if (wake_now || !role_parkable) begin
            state_nxt = ST_ON;
          end else if (tmr_done) begin
            state_nxt = ST_PARKED;
          end
        end
        ST_PARKED: begin
          if (wake_now || !role_parkable) begin
            state_nxt = ST_RAMP;
            tmr_load = 1'b1;
            tmr_val = '0;
          end
        end
        default: begin
          state_nxt = ST_OFF;
        end
      endcase
    end
  end

  delay_counter #(
    .W(CNT_W)
  ) u_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .load_i(tmr_load),
    .value_i(tmr_val),
    .done_o(tmr_done)
  );

  // ==========================================================================
  // Outputs
  // ==========================================================================
  logic alert_r;
  logic alert_nxt;
  logic pgood_r;
  logic pgood_nxt;
  logic main_en_r;
  logic main_en_nxt;
  logic parked_r;
  logic parked_nxt;
  logic sfault_r;
  logic sfault_nxt;

  always_comb begin
    req_prev_nxt = req_active;
    main_en_nxt = req_active && (state_nxt != ST_PARKED) && (state_nxt != ST_OFF);
    parked_nxt = (state_nxt == ST_PARKED);
    // Parked keeps power-good and suppresses fault reporting
    pgood_nxt = req_active && ((state_nxt == ST_ON) || (state_nxt == ST_PARK_DLY)
      || (state_nxt == ST_PARKED)) && !fault_i.input_loss;
    alert_nxt = any_event && (state_r != ST_PARKED);
    sfault_nxt = (any_fault && (state_r != ST_PARKED)) || role_zero_wr || req_drop;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r <= ST_OFF;
      role_r <= ROLE_CFG_RESET;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      req_prev_r <= 1'b0;
      alert_r <= 1'b0;
      pgood_r <= 1'b0;
      main_en_r <= 1'b0;
      parked_r <= 1'b0;
      sfault_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      role_r <= role_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      req_prev_r <= req_prev_nxt;
      alert_r <= alert_nxt;
      pgood_r <= pgood_nxt;
      main_en_r <= main_en_nxt;
      parked_r <= parked_nxt;
      sfault_r <= sfault_nxt;
    end
  end

  // Open-drain pins: level low and enable active low while pulling down
  assign alert_n_o = 1'b0;
  assign alert_n_oe_n_o = !alert_r;
  assign shared_fault_ok_n_o = 1'b0;
  assign shared_fault_ok_n_oe_n_o = !sfault_r;
  assign pgood_o = pgood_r;
  assign main_en_o = main_en_r;
  assign parked_o = parked_r;
  assign cmd_rdata_o = rdata_r;
  assign cmd_rvalid_o = rvalid_r;

endmodule // psu_ctrl

// [psu_ctrl_properties.sv]
// Assertion checker for the supply control block
`timescale 1ns/1ps
module psu_ctrl_properties import psu_ctrl_pkg::*; #(
  parameter int unsigned PWOK_DELAY_CYC = PWOK_MIN_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic remote_power_request_n_i,
  input wire fault_s fault_i,
  input wire logic outputs_in_reg_i,
  input wire logic current_limit_i,
  input wire logic wake_line_i,
  input wire logic shared_fault_line_n_i,
  input wire logic [7:0] load_share_level_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_wdata_i,
  input wire logic [7:0] cmd_rdata_o,
  input wire logic cmd_rvalid_o,
  input wire logic alert_n_o,
  input wire logic alert_n_oe_n_o,
  input wire logic pgood_o,
  input wire logic main_en_o,
  input wire logic parked_o,
  input wire logic shared_fault_ok_n_o,
  input wire logic shared_fault_ok_n_oe_n_o
);
  // ==========================================================================
  // Cycles spent on, in regulation and out of current limit
  // ==========================================================================
  logic [CNT_W-1:0] good_cnt_r;
  logic [CNT_W-1:0] good_cnt_nxt;
  always_comb begin
    good_cnt_nxt = '0;
    if (main_en_o && outputs_in_reg_i && !current_limit_i) begin
      good_cnt_nxt = good_cnt_r + 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      good_cnt_r <= '0;
    end else begin
      good_cnt_r <= good_cnt_nxt;
    end
  end
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_alert_event: assert property (
    (|fault_i[7:2]) && !parked_o |=> !alert_n_oe_n_o) else $error("alert missing");
  a_alert_quiet: assert property (
    !(|fault_i) [*2] |=> alert_n_oe_n_o) else $error("alert without event");
  a_request_off: assert property (
    remote_power_request_n_i |=> !main_en_o && !pgood_o) else $error("output left on");
  a_pgood_delay: assert property (
    $rose(pgood_o) |-> good_cnt_r >= PWOK_DELAY_CYC) else $error("power good early");
  a_pgood_reg: assert property (
    !outputs_in_reg_i && !parked_o |=> !pgood_o) else $error("power good kept");
  a_read_answer: assert property (
    cmd_rd_i ##1 !cmd_rd_i |-> cmd_rvalid_o ##1 !cmd_rvalid_o) else $error("read answer");
  a_role_cleared: assert property (
    (|fault_i) ##1 (cmd_rd_i && cmd_code_i == ROLE_CFG_OFFSET) |=>
      cmd_rdata_o == ROLE_STANDARD) else $error("role kept after fault");
  a_park_entry: assert property (
    $rose(parked_o) |-> $past(!remote_power_request_n_i && shared_fault_line_n_i))
    else $error("bad park entry");
  a_park_wake: assert property (
    parked_o && (!shared_fault_line_n_i || !wake_line_i) |=> main_en_o && !parked_o)
    else $error("no wake");
  a_parked_quiet: assert property (
    parked_o |-> alert_n_oe_n_o && pgood_o) else $error("parked state noisy");
  a_release_pull: assert property (
    $rose(remote_power_request_n_i) |=> !shared_fault_ok_n_oe_n_o) else $error("no pull");
endmodule // psu_ctrl_properties

bind psu_ctrl psu_ctrl_properties #(.PWOK_DELAY_CYC(PWOK_DELAY_CYC)) i_psu_ctrl_properties (.*);

// [host_model.sv]
// Behavioural model of the host power management controller
`timescale 1ns/1ps
module host_model import psu_ctrl_pkg::*; (
  input wire logic clk_i,
  input wire logic [7:0] cmd_rdata_i,
  input wire logic cmd_rvalid_i,
  output logic remote_power_request_n_o,
  output logic [7:0] cmd_code_o,
  output logic cmd_wr_o,
  output logic cmd_rd_o,
  output logic [7:0] cmd_wdata_o
);
  initial begin
    remote_power_request_n_o = 1'b1;
    cmd_code_o = 8'h00;
    cmd_wr_o = 1'b0;
    cmd_rd_o = 1'b0;
    cmd_wdata_o = 8'h00;
  end
  // A released request floats to the pull-up, which means off
  task automatic request(input logic on);
    @(negedge clk_i);
    remote_power_request_n_o = !on;
  endtask
  // One strobe cycle; idle lines show the inverse of the last value
  task automatic access(input logic wr, input logic [7:0] code, input logic [7:0] data,
                        output logic [7:0] rdata, output logic rvalid);
    @(negedge clk_i);
    cmd_code_o = code;
    cmd_wdata_o = data;
    cmd_wr_o = wr;
    cmd_rd_o = !wr;
    @(negedge clk_i);
    cmd_wr_o = 1'b0;
    cmd_rd_o = 1'b0;
    cmd_code_o = ~code;
    cmd_wdata_o = ~data;
    rvalid = cmd_rvalid_i;
    rdata = cmd_rdata_i;
  endtask
endmodule // host_model

// [psu_ctrl_test.sv]
// Self-checking testbench for the supply control block
`timescale 1ns/1ps
module psu_ctrl_test import psu_ctrl_pkg::*;;
  logic clk_i = 1'b0;
  logic reset_n_i;
  logic remote_power_request_n_i;
  fault_s fault_i;
  logic outputs_in_reg_i, current_limit_i, wake_line_i, other_pull;
  logic [7:0] load_share_level_i, cmd_code_i, cmd_wdata_i, cmd_rdata_o;
  logic cmd_wr_i, cmd_rd_i, cmd_rvalid_o, alert_n_o, alert_n_oe_n_o, pgood_o, main_en_o;
  logic parked_o, shared_fault_ok_n_o, shared_fault_ok_n_oe_n_o;
  wire logic shared_fault_line_n_i = (shared_fault_ok_n_oe_n_o | shared_fault_ok_n_o) & ~other_pull;
  wire logic alert_wire = alert_n_oe_n_o | alert_n_o;
  localparam logic [7:0] SHARE_TH3_TB = 8'h80;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #50 clk_i = ~clk_i;
  psu_ctrl #(.ON_DELAY_CYC(10), .PWOK_DELAY_CYC(20), .PARK1_CYC(30), .PARK2_CYC(20),
    .PARK3_CYC(10)) i_psu_ctrl (.*);
  host_model i_host_model (.clk_i(clk_i), .cmd_rdata_i(cmd_rdata_o), .cmd_rvalid_i(cmd_rvalid_o),
    .remote_power_request_n_o(remote_power_request_n_i), .cmd_code_o(cmd_code_i),
    .cmd_wr_o(cmd_wr_i), .cmd_rd_o(cmd_rd_i), .cmd_wdata_o(cmd_wdata_i));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [7:0] b(input logic x);
    return {7'h00, x};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wr(input logic [7:0] code, input logic [7:0] v);
    logic [7:0] d;
    logic ok;
    i_host_model.access(1'b1, code, v, d, ok);
  endtask
  task automatic rd(input logic [7:0] code, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    i_host_model.access(1'b0, code, 8'h00, d, ok);
    check(b(ok), 8'h01);
    check(d, exp);
  endtask
  task automatic wait_hi(ref logic flag, output int n);
    n = 0;
    while (flag !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  // Sequences the supply on, optionally holding current limit at first
  task automatic power_up(input int limit);
    int n;
    i_host_model.request(1'b0);
    cyc(2);
    current_limit_i = (limit > 0);
    i_host_model.request(1'b1);
    cyc(1);
    check(b(main_en_o), 8'h01);
    cyc(limit);
    check(b(pgood_o), 8'h00);
    current_limit_i = 1'b0;
    wait_hi(pgood_o, n);
    check(b(n >= 20 && n <= 40), 8'h01);
    check(b(alert_wire), 8'h01);
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs();
    rd(ROLE_CFG_OFFSET, ROLE_CFG_RESET);
    for (int v = 1; v < 6; v++) begin
      wr(ROLE_CFG_OFFSET, 8'(v));
      rd(ROLE_CFG_OFFSET, 8'(v));
    end
    wr(8'h10, 8'h55);
    rd(8'h10, 8'h00);
    rd(ROLE_CFG_OFFSET, ROLE_SB4);
  endtask
  task automatic t_release();
    power_up(0);
    outputs_in_reg_i = 1'b0;
    cyc(2);
    check(b(pgood_o), 8'h00);
    outputs_in_reg_i = 1'b1;
    i_host_model.request(1'b0);
    cyc(1);
    check(b(main_en_o), 8'h00);
    check(b(pgood_o), 8'h00);
    check(b(shared_fault_line_n_i), 8'h00);
  endtask
  task automatic t_faults();
    for (int i = 0; i < 8; i++) begin
      power_up(0);
      wr(ROLE_CFG_OFFSET, ROLE_SB2);
      fault_i = fault_s'(8'h01 << i);
      cyc(2);
      if (i > 1) check(b(alert_wire), 8'h00);
      if (i != 6) check(b(shared_fault_line_n_i), 8'h00);
      rd(ROLE_CFG_OFFSET, ROLE_STANDARD);
      fault_i = '0;
      cyc(2);
      check(b(alert_wire), 8'h01);
    end
  endtask
  task automatic t_nopark();
    for (int i = 0; i < 3; i++) begin
      power_up(0);
      wr(ROLE_CFG_OFFSET, 8'(i));
      other_pull = (i == 2);
      wake_line_i = 1'b1;
      cyc(50);
      check(b(parked_o), 8'h00);
      wake_line_i = 1'b0;
      other_pull = 1'b0;
    end
  endtask
  task automatic t_park(input logic [7:0] role, input int pcyc, input int how);
    int n;
    power_up(0);
    wr(ROLE_CFG_OFFSET, role);
    wake_line_i = 1'b1;
    wait_hi(parked_o, n);
    check(b(n >= pcyc && n <= pcyc + 6), 8'h01);
    check(b(pgood_o), 8'h01);
    check(b(main_en_o), 8'h00);
    case (how)
      0: wake_line_i = 1'b0;
      1: other_pull = 1'b1;
      2: load_share_level_i = SHARE_TH3_TB;
      default: fault_i.fan_fail = 1'b1;
    endcase
    cyc(1);
    check(b(main_en_o), 8'h01);
    check(b(parked_o), 8'h00);
    wake_line_i = 1'b0;
    other_pull = 1'b0;
    load_share_level_i = 8'h00;
    fault_i = '0;
  endtask
  initial begin
    reset_n_i = 1'b0;
    fault_i = '0;
    outputs_in_reg_i = 1'b1;
    current_limit_i = 1'b0;
    wake_line_i = 1'b0;
    other_pull = 1'b0;
    load_share_level_i = 8'h00;
    cyc(4);
    reset_n_i = 1'b1;
    t_regs();
    power_up(60);
    t_release();
    t_faults();
    t_nopark();
    t_park(ROLE_SB1, 30, 0);
    t_park(ROLE_SB2, 20, 1);
    t_park(ROLE_SB3, 10, 2);
    t_park(ROLE_SB4, 10, 3);
    test_done();
  end
  initial begin
    #2_000_000;
    n_mismatch++;
    test_done();
  end
endmodule // psu_ctrl_test
